//--- rtl/tib_irq_bank.sv
/*
 Second-level interrupt registers for two general-purpose timers: gate, pending and
 missed registers per timer, a register port and one interrupt level per timer.
 Assumes event strobes come from timer logic on core_clk and the register master
 keeps to the single-cycle strobe protocol.
*/
// Added by the designer: the strobed register port.
// Notes on behaviour
// R01 - Gate register: trigger 6, channels 1-4, update 0
// R02 - Pending register uses same bit positions
// R03 - Reserved pending/missed fields read-only, software ignores
// R04 - Missed register: channel 1 bit 9 to 12
// R05 - Two pending registers, consecutive words, reset zero
// R06 - Two missed registers, own words, reset zero
// R07 - Two gate registers reset zero, sources disabled
// R08 - Missed on recurrence while pending; irq pending&gate
`timescale 1ns/1ps

module tib_irq_bank (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clkEn,
   input wire tib_pkg::tib_bus_req_t busReq,
   output logic [tib_pkg::DATA_W-1:0] rdata_q,
   input wire tib_pkg::tib_events_t [tib_pkg::NUM_TIMERS-1:0] timerEvents,
   output logic [tib_pkg::NUM_TIMERS-1:0] timerIrq_q
);
   import tib_pkg::*;

   logic [SRC_W-1:0] gate_q [NUM_TIMERS];
   logic [SRC_W-1:0] gate_d [NUM_TIMERS];
   logic [SRC_W-1:0] pending_q [NUM_TIMERS];
   logic [SRC_W-1:0] pending_d [NUM_TIMERS];
   logic [CH_COUNT-1:0] missed_q [NUM_TIMERS];
   logic [CH_COUNT-1:0] missed_d [NUM_TIMERS];
   logic [NUM_TIMERS-1:0] irq_d;
   logic [DATA_W-1:0] rdata_d;

   // Event strobes mapped onto register bit positions
   function automatic logic [SRC_W-1:0] srcVector(input tib_events_t ev);
      logic [SRC_W-1:0] v;
      v = '0;
      v[TRIGGER_BIT] = ev.triggerEvent; // R02
      v[CH1_BIT +: CH_COUNT] = ev.chEvent; // R02
      v[UPDATE_BIT] = ev.updateEvent; // R02
      return v;
   endfunction

   // Next state of gate, pending and missed bits
   always_comb begin
      logic [SRC_W-1:0] events;
      logic [SRC_W-1:0] pendClr;
      logic [CH_COUNT-1:0] missClr;
      logic [CH_COUNT-1:0] missSet;
      events = '0;
      pendClr = '0;
      missClr = '0;
      missSet = '0;
      for (int t = 0; t < NUM_TIMERS; t++) begin
         events = srcVector(timerEvents[t]);
         pendClr = '0;
         missClr = '0;
         gate_d[t] = gate_q[t];
         if (busReq.wr && busReq.addr == GATE_ADDR[t]) begin
            gate_d[t] = busReq.wdata[SRC_W-1:0] & SRC_VALID_MASK; // R01
         end
         if (busReq.wr && busReq.addr == PENDING_ADDR[t]) begin
            pendClr = busReq.wdata[SRC_W-1:0];
         end
         if (busReq.wr && busReq.addr == MISSED_ADDR[t]) begin
            missClr = busReq.wdata[MISS_CH1_BIT +: CH_COUNT];
         end
         // Set beats a write-one clear in the same cycle
         pending_d[t] = ((pending_q[t] & ~pendClr) | events) & SRC_VALID_MASK; // R02
         // A flag being cleared now takes the new event, so nothing is lost
         missSet = events[CH1_BIT +: CH_COUNT] & pending_q[t][CH1_BIT +: CH_COUNT]
            & ~pendClr[CH1_BIT +: CH_COUNT]; // R08
         missed_d[t] = (missed_q[t] & ~missClr) | missSet; // R04
         irq_d[t] = |(pending_d[t] & gate_d[t]); // R08
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         for (int t = 0; t < NUM_TIMERS; t++) begin
            gate_q[t] <= GATE_RESET; // R07
         end
      end else if (clkEn) begin
         for (int t = 0; t < NUM_TIMERS; t++) begin
            gate_q[t] <= gate_d[t]; // R07
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         for (int t = 0; t < NUM_TIMERS; t++) begin
            pending_q[t] <= PENDING_RESET; // R05
         end
      end else if (clkEn) begin
         for (int t = 0; t < NUM_TIMERS; t++) begin
            pending_q[t] <= pending_d[t]; // R05
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         for (int t = 0; t < NUM_TIMERS; t++) begin
            missed_q[t] <= MISSED_RESET; // R06
         end
      end else if (clkEn) begin
         for (int t = 0; t < NUM_TIMERS; t++) begin
            missed_q[t] <= missed_d[t]; // R06
         end
      end
   end

   // Registered from next state so the level tracks the flags without extra lag
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         timerIrq_q <= '0;
      end else if (clkEn) begin
         timerIrq_q <= irq_d; // R08
      end
   end

   // Read mux; reserved fields and unmapped addresses read as zero
   always_comb begin
      rdata_d = READ_IDLE;
      if (busReq.rd) begin
         for (int t = 0; t < NUM_TIMERS; t++) begin
            if (busReq.addr == GATE_ADDR[t]) begin
               rdata_d[SRC_W-1:0] = gate_q[t]; // R01
            end
            if (busReq.addr == PENDING_ADDR[t]) begin
               rdata_d[SRC_W-1:0] = pending_q[t]; // R03
            end
            if (busReq.addr == MISSED_ADDR[t]) begin
               rdata_d[MISS_CH1_BIT +: CH_COUNT] = missed_q[t]; // R03
            end
         end
      end
   end

   // Data stands from the enabled edge that samples the read strobe until the next enabled edge
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= READ_IDLE;
      end else if (clkEn) begin
         rdata_q <= rdata_d;
      end
   end

endmodule // tib_irq_bank

//--- rtl/tib_pkg.sv
/*
 Constants, register map and carrier types of the timer interrupt flag and enable bank.
 Assumes a single 32-bit register port with byte addresses and word-aligned registers.
*/
package tib_pkg;

   localparam int NUM_TIMERS = 2;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int CH_COUNT = 4;
   localparam int SRC_W = 7;

   // Register byte addresses, index 0 is timer 1
   localparam logic [ADDR_W-1:0] PENDING_ADDR [NUM_TIMERS] = '{32'h4000_A800, 32'h4000_A804};
   localparam logic [ADDR_W-1:0] MISSED_ADDR [NUM_TIMERS] = '{32'h4000_A818, 32'h4000_A81C};
   localparam logic [ADDR_W-1:0] GATE_ADDR [NUM_TIMERS] = '{32'h4000_A840, 32'h4000_A844};

   // Field positions shared by the pending and gate registers
   localparam int UPDATE_BIT = 0;
   localparam int CH1_BIT = 1;
   localparam int TRIGGER_BIT = 6;
   localparam logic [SRC_W-1:0] SRC_VALID_MASK = 7'h5F;

   // Field positions of the missed register and reserved fields
   localparam int MISS_CH1_BIT = 9;
   localparam int PEND_RSVD_LSB = 9;
   localparam int PEND_RSVD_MSB = 12;
   localparam int MISS_RSVD_LSB = 0;
   localparam int MISS_RSVD_MSB = 6;

   // Reset values
   localparam logic [SRC_W-1:0] PENDING_RESET = 7'h00;
   localparam logic [CH_COUNT-1:0] MISSED_RESET = 4'h0;
   localparam logic [SRC_W-1:0] GATE_RESET = 7'h00;
   localparam logic [DATA_W-1:0] READ_IDLE = 32'h0000_0000;

   // One-cycle event strobes from one timer
   typedef struct packed {
      logic triggerEvent;
      logic [CH_COUNT-1:0] chEvent;
      logic updateEvent;
   } tib_events_t;

   // Register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } tib_bus_req_t;

endpackage

//--- test/tib_irq_bank_monitor.sv
/* Checker of tib_irq_bank ports; assumes one clock domain and the bind at the foot. */
`timescale 1ns/1ps
module tib_irq_bank_monitor (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clkEn,
   input wire tib_pkg::tib_bus_req_t busReq,
   input wire logic [31:0] rdata_q,
   input wire tib_pkg::tib_events_t [1:0] timerEvents,
   input wire logic [1:0] timerIrq_q
);
   import tib_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   wire rq = busReq.rd && clkEn;
   wire pr = rq && (busReq.addr inside {PENDING_ADDR});
   wire mr = rq && (busReq.addr inside {MISSED_ADDR});
   wire gr = rq && (busReq.addr inside {GATE_ADDR});
   AST_PEND: assert property (pr |=> !(rdata_q & 32'hFFFF_FFA0)) else $error("pend");
   AST_GATE: assert property (gr |=> !(rdata_q & 32'hFFFF_FFA0)) else $error("gate");
   AST_MISS: assert property (mr |=> !(rdata_q & 32'hFFFF_E1FF)) else $error("miss");
   AST_VOID: assert property (rq && !(pr || mr || gr) |=> !rdata_q) else $error("void");
   AST_IDLE: assert property (clkEn && !busReq.rd |=> !rdata_q) else $error("idle");
   AST_HOLD: assert property (!clkEn |=> $stable(timerIrq_q)) else $error("hold");
   AST_RISE: assert property ($rose(timerIrq_q[0]) |->
      $past(clkEn && (|timerEvents[0] || busReq.wr))) else $error("rise");
   AST_FALL: assert property ($fell(timerIrq_q[1]) |-> $past(busReq.wr)) else $error("fall");
   cover property (pr ##1 rdata_q != 0);
   cover property (mr ##1 rdata_q != 0);
   cover property ($rose(timerIrq_q[1]));
endmodule // tib_irq_bank_monitor
bind tib_irq_bank tib_irq_bank_monitor tib_irq_bank_monitor_i (.core_clk(core_clk), .resetn(resetn),
   .clkEn(clkEn), .busReq(busReq), .rdata_q(rdata_q), .timerEvents(timerEvents), .timerIrq_q(timerIrq_q));

//--- test/timer_irq_flag_enable_bank_tb_top.sv
/* Random bench of tib_irq_bank with a register model; assumes the monitor is compiled first. */
`timescale 1ns/1ps
module timer_irq_flag_enable_bank_tb_top;
   import tib_pkg::*;
   logic core_clk = 0, resetn = 0, clkEn = 1;
   tib_bus_req_t busReq = '0;
   tib_events_t [1:0] timerEvents = '0;
   logic [31:0] rdata_q, d;
   logic [1:0] timerIrq_q;
   logic [1:0][6:0] pe = '0, ga = '0, mi = '0;
   int err_total = 0, n_compared = 0, cyc = 0, t;
   always #2 core_clk = ~core_clk;
   tib_irq_bank tib_irq_bank_i (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
      .busReq(busReq), .rdata_q(rdata_q), .timerEvents(timerEvents), .timerIrq_q(timerIrq_q));
   task automatic conclude(int x);
      $display("compared %0d errors %0d", n_compared, err_total + x);
      if (err_total + x == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge core_clk) if (++cyc == 3000) conclude(1);
   task automatic chk(string n, logic [31:0] e, g);
      n_compared++;
      err_total += (g !== e);
      if (g !== e) $display("Error %s expected %h seen %h", n, e, g);
   endtask
   task automatic rd(logic [31:0] a, e, string n);
      @(posedge core_clk);
      busReq <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge core_clk);
      busReq <= '0;
      #1 chk(n, e, rdata_q);
   endtask
   task automatic op(logic [2:0] k); // Events sent with clkEn low must be lost
      logic [31:0] am[4] = '{GATE_ADDR[t], PENDING_ADDR[t], MISSED_ADDR[t], 32'h4000_A80C};
      @(posedge core_clk);
      busReq <= '{am[k[1:0]], d, !k[2], 1'b0};
      timerEvents[t] <= k[2] ? d[5:0] : 6'h00;
      clkEn <= !k[2] || d[7:6] != 2'h3;
      @(posedge core_clk);
      busReq <= '0;
      timerEvents <= '0;
      clkEn <= 1'b1;
      if (k == 0) ga[t] = d[6:0] & SRC_VALID_MASK;
      if (k == 1) pe[t] &= ~d[6:0];
      if (k == 2) mi[t][3:0] &= ~d[12:9];
      if (k[2] && d[7:6] != 2'h3) mi[t][3:0] |= pe[t][4:1] & d[4:1];
      if (k[2] && d[7:6] != 2'h3) pe[t] |= {d[5], 1'b0, d[4:0]};
   endtask
   task automatic chkRegs();
      rd(PENDING_ADDR[t], {25'h0, pe[t]}, "pend");
      rd(MISSED_ADDR[t], {19'h0, mi[t][3:0], 9'h0}, "miss");
      rd(GATE_ADDR[t], {25'h0, ga[t]}, "gate");
      chk("irq", {31'h0, |(pe[t] & ga[t])}, {31'h0, timerIrq_q[t]});
   endtask
   initial begin
      void'($urandom(76878));
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      for (t = 0; t < 2; t++) chkRegs();
      rd(32'h4000_A808, 32'h0, "void");
      $display("reset test done");
      // Corner: event and its clear together, set must win with no missed bit
      t = 0;
      @(posedge core_clk);
      busReq <= '{GATE_ADDR[0], 32'h0000_005F, 1'b1, 1'b0};
      timerEvents[0] <= 6'h02;
      @(posedge core_clk);
      busReq <= '{PENDING_ADDR[0], 32'h0000_0002, 1'b1, 1'b0};
      timerEvents[0] <= 6'h02;
      @(posedge core_clk);
      busReq <= '0;
      timerEvents <= '0;
      ga[0] = 7'h5F;
      pe[0] = 7'h02;
      chkRegs();
      $display("corner test done");
      repeat (200) begin
         d = $urandom;
         t = d[28];
         op(d[31:29]);
         chkRegs();
      end
      $display("random test done");
      conclude(0);
   end
endmodule // timer_irq_flag_enable_bank_tb_top
